// File: core/compressed_mem_expander.sv
`timescale 1ns/1ps
`include "tinst_defs.svh"
// Expands only the compressed loads and stores; other encodings report
// expand_ok low. Immediates are left zero because every later use clears them.
module compressed_mem_expander (
	tinst_if.expander port_x
);
	wire [1:0] quad     = port_x.half_instr[1:0];
	wire [2:0] f3       = port_x.half_instr[15:13];
	wire [4:0] rd_p     = {2'b01, port_x.half_instr[4:2]};
	wire [4:0] rs1_p    = {2'b01, port_x.half_instr[9:7]};
	wire [4:0] rd_full  = port_x.half_instr[11:7];
	wire [4:0] rs2_full = port_x.half_instr[6:2];
	wire [2:0] width    = (f3[1:0] == 2'b10) ? 3'h2 : 3'h3;
	wire       is_fp    = (f3[1:0] == 2'b01);
	wire [6:0] ld_op    = is_fp ? `OP_LOAD_FP : `OP_LOAD;
	wire [6:0] st_op    = is_fp ? `OP_STORE_FP : `OP_STORE;
	wire       mem_f3   = (f3[1:0] != 2'b00);

	// Quadrant 0 uses the short register fields, quadrant 2 the stack pointer.
	wire q0_ld = (quad == 2'b00) && !f3[2] && mem_f3;
	wire q0_st = (quad == 2'b00) &&  f3[2] && mem_f3;
	wire q2_ld = (quad == 2'b10) && !f3[2] && mem_f3 && (is_fp || rd_full != 5'h00);
	wire q2_st = (quad == 2'b10) &&  f3[2] && mem_f3;

	assign port_x.expand_ok  = q0_ld || q0_st || q2_ld || q2_st;
	assign port_x.full_instr =
		q0_ld ? {12'h000, rs1_p, width, rd_p, ld_op} :
		q0_st ? {7'h00, rd_p, rs1_p, width, 5'h00, st_op} :
		q2_ld ? {12'h000, 5'h02, width, rd_full, ld_op} :
		q2_st ? {7'h00, rs2_full, 5'h02, width, 5'h00, st_op} :
		32'h0000_0000;
endmodule : compressed_mem_expander

// File: core/tinst_defs.svh
`ifndef TINST_DEFS_SVH
`define TINST_DEFS_SVH

// ****************************************************************
// Register map (byte addresses on the APB side)
// ****************************************************************
`define TINST_OFS_CTRL      12'h000
`define TINST_OFS_MVAL      12'h004
`define TINST_OFS_HVAL      12'h008
`define TINST_OFS_STATUS    12'h00c

`define TINST_CTRL_XFORM_BIT  0
`define TINST_CTRL_CUSTOM_BIT 1
`define TINST_CTRL_ADWR_BIT   2
`define TINST_CTRL_RESET      3'h7

// ****************************************************************
// Trap causes
// ****************************************************************
`define CAUSE_INSTR_ACCESS     5'h01
`define CAUSE_ILLEGAL          5'h02
`define CAUSE_LOAD_MISALIGN    5'h04
`define CAUSE_LOAD_ACCESS      5'h05
`define CAUSE_STORE_MISALIGN   5'h06
`define CAUSE_STORE_ACCESS     5'h07
`define CAUSE_INSTR_PAGE       5'h0c
`define CAUSE_LOAD_PAGE        5'h0d
`define CAUSE_STORE_PAGE       5'h0f
`define CAUSE_INSTR_GUEST_PAGE 5'h14
`define CAUSE_LOAD_GUEST_PAGE  5'h15
`define CAUSE_STORE_GUEST_PAGE 5'h17

// ****************************************************************
// Major opcodes
// ****************************************************************
`define OP_LOAD     7'h03
`define OP_LOAD_FP  7'h07
`define OP_STORE    7'h23
`define OP_STORE_FP 7'h27
`define OP_AMO      7'h2f
`define OP_SYSTEM   7'h73

// ****************************************************************
// Pseudoinstruction values
// ****************************************************************
`define PSEUDO_READ_32  32'h00002000
`define PSEUDO_WRITE_32 32'h00002020
`define PSEUDO_READ_64  32'h00003000
`define PSEUDO_WRITE_64 32'h00003020

`endif

// File: core/tinst_if.sv
`timescale 1ns/1ps
interface tinst_if;
	logic [15:0] half_instr;
	logic [31:0] full_instr;
	logic        expand_ok;

	modport requester (output half_instr, input full_instr, input expand_ok);
	modport expander  (input half_instr, output full_instr, output expand_ok);
endinterface : tinst_if

// File: core/tinst_pkg.sv
package tinst_pkg;

	typedef enum logic [1:0] {
		VAL_ZERO,
		VAL_XFORM,
		VAL_CUSTOM,
		VAL_PSEUDO
	} value_class_t;

endpackage : tinst_pkg

// File: core/trap_instruction_value_gen.sv
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "tinst_defs.svh"
// Behaviour
// - Every trap into machine or hypervisor level loads that level's value register.
// - An interrupt always writes zero.
// - Fetch-blocking exceptions write only zero or a pseudoinstruction.
// - Custom values only for non-standard trapping instructions.
// - Transformed values only for explicit load, store or atomic accesses.
// - Instruction access and illegal write zero; breakpoint, virtual may write custom.
// - Standard instruction without transformation writes zero or a pseudoinstruction.
// - Transformed load keeps function code, destination and opcode fields.
// - Transformed store keeps second source, function code and opcode fields.
// - Atomic transform equals instruction except bits 19:15 holding offset.
// - Guest virtual load/store transform equals instruction except offset bits 19:15.
// - Offset field is faulting address minus original address.
// - Basic load and store transforms clear immediate fields.
// - Compressed instruction is expanded, transformed, then bit 1 cleared.
// - Transformed value ends in 01 if compressed, 11 otherwise.
// - Implicit translation guest-page fault with nonzero address writes a pseudoinstruction.
// - Guest supervisor width selects 32-bit or 64-bit pseudoinstruction values.
// - Write pseudoinstruction only for accessed/dirty updates; all else reads.
// - Value registers stay writable when pseudoinstructions may arise; here APB writes to MVAL and HVAL are ignored.
// - Custom value need not relate to the trapping instruction.
module trap_instruction_value_gen
	import tinst_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Trap entry from the core
	input  wire logic        trap_valid,
	input  wire logic        trap_to_hyper,
	input  wire logic        trap_is_interrupt,
	input  wire logic [4:0]  trap_cause,
	input  wire logic [31:0] trap_instr,
	input  wire logic        instr_nonstandard,
	input  wire logic [31:0] custom_value,
	input  wire logic [63:0] fault_vaddr,
	input  wire logic [63:0] orig_vaddr,
	// Guest translation context
	input  wire logic        implicit_xlate,
	input  wire logic        implicit_ad_update,
	input  wire logic        guest_fault_addr_nonzero,
	input  wire logic        guest_supervisor_width,
	// Trap instruction values
	output logic      [63:0] machine_tinst,
	output logic      [63:0] hyper_tinst,
	output logic             tinst_write,
	output value_class_t     tinst_class
);

	// ****************************************************************
	// Compressed expansion
	// ****************************************************************
	tinst_if exp_bus ();

	compressed_mem_expander u_expander (
		.port_x (exp_bus.expander)
	);

	wire        is_compressed = (trap_instr[1:0] != 2'b11);
	assign exp_bus.half_instr = trap_instr[15:0];
	wire [31:0] base_instr    = is_compressed ? exp_bus.full_instr : trap_instr;

	// ****************************************************************
	// Instruction kind
	// ****************************************************************
	wire [6:0] opc   = base_instr[6:0];
	wire [2:0] fn3   = base_instr[14:12];
	wire       fp_w  = (fn3 >= 3'h1) && (fn3 <= 3'h4);
	wire       is_ld = ((opc == `OP_LOAD) && (fn3 != 3'h7)) || ((opc == `OP_LOAD_FP) && fp_w);
	wire       is_st = ((opc == `OP_STORE) && (fn3 <= 3'h3)) || ((opc == `OP_STORE_FP) && fp_w);
	wire       is_amo = (opc == `OP_AMO) && ((fn3 == 3'h2) || (fn3 == 3'h3));
	wire       is_hvm = (opc == `OP_SYSTEM) && (fn3 == 3'h4) && (base_instr[31:29] == 3'h3);
	wire       kind_ok = !is_compressed || exp_bus.expand_ok;
	wire       mem_kind = kind_ok && !instr_nonstandard && (is_ld || is_st || is_amo || is_hvm);

	// ****************************************************************
	// Transformation
	// ****************************************************************
	// Only the low five bits matter: a misaligned access never strays further.
	wire [4:0]  addr_off = fault_vaddr[4:0] - orig_vaddr[4:0];
	wire [31:0] ld_form  = {12'h000, addr_off, fn3, base_instr[11:7], opc};
	wire [31:0] st_form  = {7'h00, base_instr[24:20], addr_off, fn3, 5'h00, opc};
	wire [31:0] rmw_form = {base_instr[31:20], addr_off, base_instr[14:0]};
	wire [31:0] xf_full  = is_ld ? ld_form : (is_st ? st_form : rmw_form);
	wire [31:0] xf_value = {xf_full[31:2], !is_compressed, 1'b1};

	// ****************************************************************
	// Cause filtering
	// ****************************************************************
	wire c_ld_st = (trap_cause == `CAUSE_LOAD_MISALIGN) || (trap_cause == `CAUSE_LOAD_ACCESS)
		|| (trap_cause == `CAUSE_STORE_MISALIGN) || (trap_cause == `CAUSE_STORE_ACCESS)
		|| (trap_cause == `CAUSE_LOAD_PAGE) || (trap_cause == `CAUSE_STORE_PAGE);
	wire c_gpf_data = (trap_cause == `CAUSE_LOAD_GUEST_PAGE)
		|| (trap_cause == `CAUSE_STORE_GUEST_PAGE);
	wire c_fetch = (trap_cause == `CAUSE_INSTR_ACCESS) || (trap_cause == `CAUSE_INSTR_PAGE)
		|| (trap_cause == `CAUSE_INSTR_GUEST_PAGE);
	wire c_xform  = c_ld_st || c_gpf_data;
	wire c_custom = !c_fetch && (trap_cause != `CAUSE_ILLEGAL);
	wire c_pseudo = c_gpf_data || (trap_cause == `CAUSE_INSTR_GUEST_PAGE);

	// ****************************************************************
	// Control register
	// ****************************************************************
	logic [2:0] ctrl_reg;
	logic [2:0] ctrl_next;
	wire        xform_en  = ctrl_reg[`TINST_CTRL_XFORM_BIT];
	wire        custom_en = ctrl_reg[`TINST_CTRL_CUSTOM_BIT];
	wire        adwr_en   = ctrl_reg[`TINST_CTRL_ADWR_BIT];

	// ****************************************************************
	// Value selection
	// ****************************************************************
	wire pseudo_hit = c_pseudo && implicit_xlate && guest_fault_addr_nonzero;
	wire pseudo_wr  = implicit_ad_update && adwr_en;
	wire [31:0] pseudo_val = guest_supervisor_width
		? (pseudo_wr ? `PSEUDO_WRITE_64 : `PSEUDO_READ_64)
		: (pseudo_wr ? `PSEUDO_WRITE_32 : `PSEUDO_READ_32);
	wire xform_hit  = c_xform && mem_kind && xform_en;
	wire custom_hit = c_custom && instr_nonstandard && custom_en;

	value_class_t sel_class;
	assign sel_class = trap_is_interrupt ? VAL_ZERO :
		pseudo_hit ? VAL_PSEUDO :
		xform_hit ? VAL_XFORM :
		custom_hit ? VAL_CUSTOM : VAL_ZERO;

	wire [31:0] sel_low = (sel_class == VAL_PSEUDO) ? pseudo_val :
		(sel_class == VAL_XFORM) ? xf_value :
		(sel_class == VAL_CUSTOM) ? custom_value : 32'h0000_0000;
	wire [63:0] sel_value = {32'h0000_0000, sel_low};

	// ****************************************************************
	// Trap value registers
	// ****************************************************************
	logic [63:0] mval_reg;
	logic [63:0] hval_reg;
	logic        write_reg;
	logic        last_hyper_reg;
	value_class_t class_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mval_reg       <= 64'h0;
			hval_reg       <= 64'h0;
			write_reg      <= 1'b0;
			last_hyper_reg <= 1'b0;
			class_reg      <= VAL_ZERO;
		end else begin
			write_reg <= trap_valid;
			if (trap_valid) begin
				class_reg      <= sel_class;
				last_hyper_reg <= trap_to_hyper;
			end
			if (trap_valid && !trap_to_hyper) begin
				mval_reg <= sel_value;
			end
			if (trap_valid && trap_to_hyper) begin
				hval_reg <= sel_value;
			end
		end
	end

	assign machine_tinst = mval_reg;
	assign hyper_tinst   = hval_reg;
	assign tinst_write   = write_reg;
	assign tinst_class   = class_reg;

	// ****************************************************************
	// APB slave
	// ****************************************************************
	// One wait-free access: answer is prepared in the setup cycle so that
	// prdata and pready come straight from flip-flops.
	wire setup_ph  = psel && !penable;
	wire hit_ctrl  = (paddr == `TINST_OFS_CTRL);
	wire hit_mval  = (paddr == `TINST_OFS_MVAL);
	wire hit_hval  = (paddr == `TINST_OFS_HVAL);
	wire hit_stat  = (paddr == `TINST_OFS_STATUS);
	wire mapped    = hit_ctrl || hit_mval || hit_hval || hit_stat;
	wire wr_commit = psel && penable && pready && pwrite && hit_ctrl;

	wire [31:0] rd_mux = hit_ctrl ? {29'h0, ctrl_reg} :
		hit_mval ? mval_reg[31:0] :
		hit_hval ? hval_reg[31:0] :
		hit_stat ? {29'h0, last_hyper_reg, class_reg} : 32'h0000_0000;

	assign ctrl_next = wr_commit ? pwdata[2:0] : ctrl_reg;

	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg    <= `TINST_CTRL_RESET;
			prdata_reg  <= 32'h0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			ctrl_reg    <= ctrl_next;
			pready_reg  <= setup_ph;
			pslverr_reg <= setup_ph && !mapped;
			if (setup_ph && !pwrite) begin
				prdata_reg <= rd_mux;
			end
		end
	end

	assign prdata  = prdata_reg;
	assign pready  = pready_reg;
	assign pslverr = pslverr_reg;

endmodule : trap_instruction_value_gen

// File: dv/core_trap_model.sv
`timescale 1ns/1ps
module core_trap_model (
	input  wire logic        pclk,
	// Trap request towards the value generator
	output logic             trap_valid,
	output logic             trap_to_hyper,
	output logic             trap_is_interrupt,
	output logic      [4:0]  trap_cause,
	output logic      [31:0] trap_instr,
	output logic             instr_nonstandard,
	output logic      [31:0] custom_value,
	output logic      [63:0] fault_vaddr,
	output logic      [63:0] orig_vaddr,
	output logic             implicit_xlate,
	output logic             implicit_ad_update,
	output logic             guest_fault_addr_nonzero,
	output logic             guest_supervisor_width
);
	localparam logic [63:0] BASE_VA = 64'h0000_0000_8000_1000;

	assign custom_value = 32'h0000_100b;
	initial {trap_valid, trap_to_hyper, trap_is_interrupt, trap_cause, trap_instr,
		instr_nonstandard, fault_vaddr, orig_vaddr, implicit_xlate, implicit_ad_update,
		guest_fault_addr_nonzero, guest_supervisor_width} = '0;

	// Flags: 0 hyper, 1 interrupt, 2 non-standard, 3 implicit, 4 A/D update, 5 wide guest.
	// After the pulse the instruction bus carries junk, so a stale copy cannot pass.
	task automatic fire(input logic [5:0] f, input logic [4:0] c, input logic [31:0] ins,
		input logic [4:0] o);
		@(posedge pclk);
		trap_valid <= 1'b1;
		trap_to_hyper <= f[0];
		trap_is_interrupt <= f[1];
		instr_nonstandard <= f[2];
		implicit_xlate <= f[3];
		guest_fault_addr_nonzero <= f[3];
		implicit_ad_update <= f[4];
		guest_supervisor_width <= f[5];
		trap_cause <= c;
		trap_instr <= ins;
		orig_vaddr <= BASE_VA;
		fault_vaddr <= BASE_VA + 64'(o);
		@(posedge pclk);
		trap_valid <= 1'b0;
		trap_instr <= ~ins;
	endtask : fire
endmodule : core_trap_model

// File: dv/test_trap_instruction_value_gen.sv
`timescale 1ns/1ps
`include "tinst_defs.svh"
module test_trap_instruction_value_gen
	import tinst_pkg::*;
;
	logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0]  paddr = 12'h000;
	logic [31:0]  pwdata = 32'h0, prdata, custom_value, trap_instr, rd;
	logic         pready, pslverr, tinst_write, trap_valid, trap_to_hyper, trap_is_interrupt;
	logic         instr_nonstandard, implicit_xlate, implicit_ad_update, err;
	logic         guest_fault_addr_nonzero, guest_supervisor_width;
	logic [4:0]   trap_cause;
	logic [63:0]  fault_vaddr, orig_vaddr, machine_tinst, hyper_tinst;
	value_class_t tinst_class;
	int           n_errors = 0, total_checks = 0, cyc = 0;

	always #5 pclk = ~pclk;

	core_trap_model i_core (.pclk(pclk), .trap_valid(trap_valid), .trap_to_hyper(trap_to_hyper),
		.trap_is_interrupt(trap_is_interrupt), .trap_cause(trap_cause), .trap_instr(trap_instr),
		.instr_nonstandard(instr_nonstandard), .custom_value(custom_value),
		.fault_vaddr(fault_vaddr), .orig_vaddr(orig_vaddr), .implicit_xlate(implicit_xlate),
		.implicit_ad_update(implicit_ad_update), .guest_fault_addr_nonzero(guest_fault_addr_nonzero),
		.guest_supervisor_width(guest_supervisor_width));
	trap_instruction_value_gen i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .trap_valid(trap_valid), .trap_to_hyper(trap_to_hyper),
		.trap_is_interrupt(trap_is_interrupt), .trap_cause(trap_cause), .trap_instr(trap_instr),
		.instr_nonstandard(instr_nonstandard), .custom_value(custom_value),
		.fault_vaddr(fault_vaddr), .orig_vaddr(orig_vaddr), .implicit_xlate(implicit_xlate),
		.implicit_ad_update(implicit_ad_update), .guest_fault_addr_nonzero(guest_fault_addr_nonzero),
		.guest_supervisor_width(guest_supervisor_width), .machine_tinst(machine_tinst),
		.hyper_tinst(hyper_tinst), .tinst_write(tinst_write), .tinst_class(tinst_class));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic trap(input logic [5:0] f, input logic [4:0] c, input logic [31:0] ins,
		input logic [4:0] o, input logic [31:0] v, input value_class_t k);
		i_core.fire(f, c, ins, o);
		#1;
		chk(f[0] ? hyper_tinst : machine_tinst, {32'h0, v});
		chk(64'(tinst_class), 64'(k));
	endtask : trap

	task automatic t_memory;
		trap(6'h02, `CAUSE_LOAD_MISALIGN, 32'habc2a483, 5'd3, 32'h0, VAL_ZERO);
		trap(6'h00, `CAUSE_LOAD_MISALIGN, 32'habc2a483, 5'd3, 32'h1a483, VAL_XFORM);
		trap(6'h01, `CAUSE_STORE_ACCESS, 32'haa72afa3, 5'd0, 32'h702023, VAL_XFORM);
		chk(machine_tinst, 64'h1a483);
		trap(6'h00, `CAUSE_STORE_PAGE, 32'h046525af, 5'd2, 32'h046125af, VAL_XFORM);
		trap(6'h01, `CAUSE_LOAD_GUEST_PAGE, 32'h680646f3, 5'd1, 32'h6800c6f3, VAL_XFORM);
		trap(6'h00, `CAUSE_LOAD_ACCESS, 32'h4004, 5'd0, 32'h2481, VAL_XFORM);
	endtask : t_memory

	task automatic t_regs;
		apb(1'b0, `TINST_OFS_CTRL, 32'h0);
		chk(rd, 32'h7);
		apb(1'b0, `TINST_OFS_STATUS, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, `TINST_OFS_MVAL, 32'hffff_ffff);
		apb(1'b0, `TINST_OFS_MVAL, 32'h0);
		chk(rd, 32'h2481);
		apb(1'b0, `TINST_OFS_HVAL, 32'h0);
		chk(rd, 32'h6800c6f3);
		apb(1'b1, 12'h010, 32'h0);
		chk(64'(err), 64'h1);
		apb(1'b1, `TINST_OFS_CTRL, 32'h6);
		trap(6'h00, `CAUSE_LOAD_ACCESS, 32'habc2a483, 5'd0, 32'h0, VAL_ZERO);
		apb(1'b1, `TINST_OFS_CTRL, 32'h7);
	endtask : t_regs

	task automatic t_other;
		logic [31:0] pv [4] = '{32'h2000, 32'h2020, 32'h3000, 32'h3020};
		trap(6'h04, `CAUSE_ILLEGAL, 32'h0000000b, 5'd0, 32'h0, VAL_ZERO);
		trap(6'h04, `CAUSE_INSTR_ACCESS, 32'h0000000b, 5'd0, 32'h0, VAL_ZERO);
		trap(6'h04, `CAUSE_INSTR_PAGE, 32'h0000000b, 5'd0, 32'h0, VAL_ZERO);
		trap(6'h05, 5'h03, 32'h0000000b, 5'd0, 32'h100b, VAL_CUSTOM);
		trap(6'h01, `CAUSE_LOAD_ACCESS, 32'h00b50533, 5'd0, 32'h0, VAL_ZERO);
		for (int k = 0; k < 4; k++) begin
			trap({k[1], k[0], 4'h9}, `CAUSE_INSTR_GUEST_PAGE, 32'h13, 5'd0, pv[k], VAL_PSEUDO);
		end
	endtask : t_other

	task automatic stop_test;
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 2000) begin
			n_errors++;
			stop_test();
		end
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_memory();
		t_regs();
		t_other();
		stop_test();
	end
endmodule : test_trap_instruction_value_gen

bind trap_instruction_value_gen trap_value_properties u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .trap_valid(trap_valid),
	.trap_to_hyper(trap_to_hyper), .trap_is_interrupt(trap_is_interrupt),
	.trap_cause(trap_cause), .instr_nonstandard(instr_nonstandard),
	.machine_tinst(machine_tinst), .hyper_tinst(hyper_tinst), .tinst_write(tinst_write),
	.tinst_class(tinst_class));

// File: dv/trap_value_properties.sv
`timescale 1ns/1ps
module trap_value_properties
	import tinst_pkg::*;
(
	// Clock, reset and bus handshake
	input wire logic         pclk,
	input wire logic         presetn,
	input wire logic         psel,
	input wire logic         penable,
	input wire logic         pready,
	// Trap entry and results
	input wire logic         trap_valid,
	input wire logic         trap_to_hyper,
	input wire logic         trap_is_interrupt,
	input wire logic  [4:0]  trap_cause,
	input wire logic         instr_nonstandard,
	input wire logic  [63:0] machine_tinst,
	input wire logic  [63:0] hyper_tinst,
	input wire logic         tinst_write,
	input wire value_class_t tinst_class
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_write_pulse: assert property (trap_valid |=> tinst_write)
		else $error("no value write after a trap");
	a_write_only: assert property (!trap_valid |=> !tinst_write)
		else $error("value write without a trap");
	a_level_hold: assert property (trap_valid && !trap_to_hyper |=> $stable(hyper_tinst))
		else $error("hyper value changed on a machine trap");
	a_irq_zero: assert property (trap_valid && trap_is_interrupt |=> tinst_class == VAL_ZERO
		&& ($past(trap_to_hyper) ? hyper_tinst : machine_tinst) == 64'h0)
		else $error("interrupt wrote a nonzero value");
	a_fetch_class: assert property (trap_valid && !trap_is_interrupt
		&& trap_cause inside {5'h01, 5'h0c, 5'h14} |=> tinst_class inside {VAL_ZERO, VAL_PSEUDO})
		else $error("fetch fault wrote a disallowed class");
	a_custom_gate: assert property (trap_valid && !instr_nonstandard |=> tinst_class != VAL_CUSTOM)
		else $error("custom value for a standard instruction");
	a_access_zero: assert property (trap_valid && trap_cause inside {5'h01, 5'h02}
		|=> tinst_class == VAL_ZERO)
		else $error("access fault or illegal wrote nonzero");
	a_xform_tail: assert property (tinst_write && tinst_class == VAL_XFORM
		|-> ($past(trap_to_hyper) ? hyper_tinst[0] : machine_tinst[0]))
		else $error("transformed value with bit 0 clear");
	a_upper_zero: assert property (machine_tinst[63:32] == 32'h0 && hyper_tinst[63:32] == 32'h0)
		else $error("upper half of a value is nonzero");
	a_bus_answer: assert property (psel && !penable |=> pready)
		else $error("access phase without ready");
endmodule : trap_value_properties
